// ===== logic/ertile_pkg.sv
package ertile_pkg;

	// ============================================================
	// Tile sizes
	localparam int TILE_SMALL  = 0;
	localparam int TILE_MEDIUM = 1;
	localparam int TILE_LARGE  = 2;

	// ============================================================
	// Stored bits per tile, parity included
	localparam int CAP_SMALL  = 576;
	localparam int CAP_MEDIUM = 4608;
	localparam int CAP_LARGE  = 589824;

	// ============================================================
	// Operating modes
	typedef enum logic [2:0] {
		MODE_SP    = 3'h0,
		MODE_SDP   = 3'h1,
		MODE_TDP   = 3'h3,
		MODE_SHIFT = 3'h2,
		MODE_ROM   = 3'h6
	} ertile_mode_t;

	// ============================================================
	// Values after reset or clear
	localparam logic RST_FLAG      = 1'b0;
	localparam logic CLR_PEND      = 1'b1;
	localparam logic RST_PEND      = 1'b0;

	// Capacity of a tile size
	function automatic int tile_cap(input int tile);
		case (tile)
			TILE_SMALL:  tile_cap = CAP_SMALL;
			TILE_MEDIUM: tile_cap = CAP_MEDIUM;
			default:     tile_cap = CAP_LARGE;
		endcase
	endfunction

endpackage

// ===== logic/ertile_store.sv
`timescale 1ns/1ns
module ertile_store #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 128,
	parameter int AW    = 7
) (
	// Clock
	input  wire logic             clk,
	// Port A write and read
	input  wire logic             a_we,
	input  wire logic [AW-1:0]    a_addr,
	input  wire logic [WIDTH-1:0] a_mask,
	input  wire logic [WIDTH-1:0] a_data,
	output logic      [WIDTH-1:0] a_rdata,
	// Port B write and read
	input  wire logic             b_we,
	input  wire logic [AW-1:0]    b_addr,
	input  wire logic [WIDTH-1:0] b_mask,
	input  wire logic [WIDTH-1:0] b_data,
	output logic      [WIDTH-1:0] b_rdata
);

	// ============================================================
	// Storage array
	logic [WIDTH-1:0] mem [DEPTH];

	assign a_rdata = mem[a_addr];
	assign b_rdata = mem[b_addr];

	// Port A written last so it wins a shared word
	always_ff @(posedge clk) begin
		if (b_we) begin
			mem[b_addr] <= (mem[b_addr] & ~b_mask) | (b_data & b_mask);
		end
		if (a_we) begin
			mem[a_addr] <= (mem[a_addr] & ~a_mask) | (a_data & a_mask);
		end
	end

endmodule

// ===== logic/ertile_top.sv
`timescale 1ns/1ns
// Summary of operation
// - Three tile sizes: small, medium, large
// - Capacities 576, 4608, 589824 bits with parity
// - Modes SP, SDP, TDP, shift, ROM by tile
// - Parity, byte enables on every tile (ignored in shift mode); pack not small
// - Address enable (not small), mixed widths, per-port enables
// - Simple dual-port mixed widths on every tile
// - True dual-port mixed widths not on small
// - Input clear acts at once, no clock
// - Output shows input clear at next edge
// - Output clear shows on outputs at once
// - Same-port read-during-write returns new data, old data in shift mode
// - Mixed-port read-during-write gives old or undefined data
module ertile_top
	import ertile_pkg::*;
#(
	parameter int TILE     = TILE_MEDIUM,
	parameter int DATA_W_A = 36,
	parameter int NBE      = 4,
	parameter int RATIO    = 1,
	localparam int DATA_W_B = DATA_W_A / RATIO,
	localparam int NBE_B    = NBE / RATIO,
	localparam int UNIT     = DATA_W_A / NBE,
	localparam int DEPTH    = tile_cap(TILE) / DATA_W_A,
	localparam int AW       = $clog2(DEPTH),
	localparam int BAW      = AW + $clog2(RATIO)
) (
	// Clock and reset
	input  wire logic                CLK,
	input  wire logic                SYS_RST,
	// Configuration
	input  wire logic [2:0]          MODE,
	input  wire logic                PACK,
	// Port A
	input  wire logic                CE_A,
	input  wire logic                ADDR_CE_A,
	input  wire logic                WE_A,
	input  wire logic [AW-1:0]       ADDR_A,
	input  wire logic [DATA_W_A-1:0] DIN_A,
	input  wire logic [NBE-1:0]      BE_A,
	input  wire logic                CLR_IN_A,
	input  wire logic                CLR_OUT_A,
	output logic      [DATA_W_A-1:0] Q_A,
	// Port B
	input  wire logic                CE_B,
	input  wire logic                ADDR_CE_B,
	input  wire logic                WE_B,
	input  wire logic [BAW-1:0]      ADDR_B,
	input  wire logic [DATA_W_B-1:0] DIN_B,
	input  wire logic [NBE_B-1:0]    BE_B,
	input  wire logic                CLR_IN_B,
	input  wire logic                CLR_OUT_B,
	output logic      [DATA_W_B-1:0] Q_B,
	// Status
	output logic                     CFG_ERR,
	output logic                     RDW_CLASH
);

	// ============================================================
	// Helpers
	function automatic logic [DATA_W_A-1:0] be_mask(input logic [NBE-1:0] be);
		for (int i = 0; i < DATA_W_A; i++) begin
			be_mask[i] = be[i / UNIT];
		end
	endfunction

	function automatic logic [DATA_W_A-1:0] merge(input logic [DATA_W_A-1:0] old,
		input logic [DATA_W_A-1:0] din, input logic [DATA_W_A-1:0] m);
		merge = (old & ~m) | (din & m);
	endfunction

	function automatic logic [DATA_W_A-1:0] place(input logic [DATA_W_A-1:0] v,
		input int sel);
		place = v << (sel * DATA_W_B);
	endfunction

	function automatic logic [DATA_W_B-1:0] pick(input logic [DATA_W_A-1:0] v,
		input int sel);
		logic [DATA_W_A-1:0] t;
		t = v >> (sel * DATA_W_B);
		pick = t[DATA_W_B-1:0];
	endfunction

	function automatic logic [AW-1:0] pack_addr(input logic [AW-1:0] a,
		input logic half);
		pack_addr = a;
		if (PACK) begin
			pack_addr[AW-1] = half;
		end
	endfunction

	// ============================================================
	// Configuration check
	ertile_mode_t mode;
	logic         next_cfg_err;
	assign mode = ertile_mode_t'(MODE);

	always_comb begin
		next_cfg_err = 1'b0;
		if (mode == MODE_TDP && TILE == TILE_SMALL) next_cfg_err = 1'b1;
		if ((mode == MODE_SHIFT || mode == MODE_ROM) && TILE == TILE_LARGE) next_cfg_err = 1'b1;
		if (PACK && TILE == TILE_SMALL) next_cfg_err = 1'b1;
		if (mode == MODE_TDP && RATIO != 1 && TILE == TILE_SMALL) next_cfg_err = 1'b1;
		if (!(mode inside {MODE_SP, MODE_SDP, MODE_TDP, MODE_SHIFT, MODE_ROM}))
			next_cfg_err = 1'b1;
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			CFG_ERR <= RST_FLAG;
		end else begin
			CFG_ERR <= next_cfg_err;
		end
	end

	// ============================================================
	// Input registers
	logic                a_pend, b_pend, a_we, b_we;
	logic [AW-1:0]       a_addr;
	logic [BAW-1:0]      b_addr;
	logic [DATA_W_A-1:0] a_din;
	logic [DATA_W_B-1:0] b_din;
	logic [NBE-1:0]      a_be;
	logic [NBE_B-1:0]    b_be;

	// input clear acts without a clock
	always_ff @(posedge CLK or posedge SYS_RST or posedge CLR_IN_A) begin
		if (SYS_RST || CLR_IN_A) begin
			a_addr <= '0;
			a_din  <= '0;
			a_we   <= 1'b0;
			a_be   <= '0;
		end else if (CE_A) begin
			// address enable, absent on small tile
			if (ADDR_CE_A || TILE == TILE_SMALL) a_addr <= ADDR_A;
			a_din <= DIN_A;
			a_we  <= WE_A;
			a_be  <= BE_A;
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST or posedge CLR_IN_B) begin
		if (SYS_RST || CLR_IN_B) begin
			b_addr <= '0;
			b_din  <= '0;
			b_we   <= 1'b0;
			b_be   <= '0;
		end else if (CE_B) begin
			if (ADDR_CE_B || TILE == TILE_SMALL) b_addr <= ADDR_B;
			b_din <= DIN_B;
			b_we  <= WE_B;
			b_be  <= BE_B;
		end
	end

	// cleared inputs reach the output at the next edge
	always_ff @(posedge CLK or posedge SYS_RST or posedge CLR_IN_A) begin
		if (SYS_RST) begin
			a_pend <= RST_PEND;
		end else if (CLR_IN_A) begin
			a_pend <= CLR_PEND;
		end else begin
			a_pend <= CE_A;
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST or posedge CLR_IN_B) begin
		if (SYS_RST) begin
			b_pend <= RST_PEND;
		end else if (CLR_IN_B) begin
			b_pend <= CLR_PEND;
		end else begin
			b_pend <= CE_B;
		end
	end

	// ============================================================
	// Shift-register pointer
	logic [AW-1:0] sh_ptr;

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			sh_ptr <= '0;
		end else if (a_pend && mode == MODE_SHIFT) begin
			sh_ptr <= (32'(sh_ptr) == DEPTH - 1) ? '0 : AW'(32'(sh_ptr) + 1);
		end
	end

	// ============================================================
	// Access decode
	logic [AW-1:0]       a_word, b_word;
	int                  b_sel;
	logic                a_wr, b_wr;
	logic [DATA_W_A-1:0] a_old, b_old, a_mask, b_mask, b_data;

	assign a_word = pack_addr((mode == MODE_SHIFT) ? sh_ptr : a_addr, 1'b0);
	assign b_word = pack_addr(AW'(32'(b_addr) / RATIO), 1'b1);
	assign b_sel  = int'(32'(b_addr) % RATIO);
	// byte enables mask writes, each unit with its parity bit
	assign a_mask = be_mask(a_be);
	// narrower port B lands on its slice
	assign b_mask = place(be_mask(NBE'(b_be)), b_sel);
	assign b_data = place(DATA_W_A'(b_din), b_sel);
	// writes gated by each port's enable
	assign a_wr = a_pend && !CFG_ERR && (mode == MODE_SHIFT || (a_we && mode != MODE_ROM));
	assign b_wr = b_pend && !CFG_ERR && b_we && mode == MODE_TDP;

	ertile_store #(
		.WIDTH (DATA_W_A),
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_store (
		.clk     (CLK),
		.a_we    (a_wr),
		.a_addr  (a_word),
		.a_mask  ((mode == MODE_SHIFT) ? '1 : a_mask),
		.a_data  (a_din),
		.a_rdata (a_old),
		.b_we    (b_wr),
		.b_addr  (b_word),
		.b_mask  (b_mask),
		.b_data  (b_data),
		.b_rdata (b_old)
	);

	// ============================================================
	// Output registers
	logic [DATA_W_A-1:0] next_q_a;
	logic [DATA_W_B-1:0] next_q_b;
	logic                next_clash;

	// same-port read returns the written data, except in shift mode where the old word is read
	assign next_q_a = (a_wr && mode != MODE_SHIFT) ? merge(a_old, a_din, a_mask) : a_old;
	assign next_q_b = b_wr ? pick(merge(b_old, b_data, b_mask), b_sel) : pick(b_old, b_sel);
	// other-port write to same word gives old data and a flag
	assign next_clash = b_pend && a_pend && (a_wr || b_wr) && (a_word == b_word);

	always_ff @(posedge CLK or posedge SYS_RST or posedge CLR_OUT_A) begin
		if (SYS_RST || CLR_OUT_A) begin
			Q_A <= '0;
		end else if (a_pend) begin
			Q_A <= next_q_a;
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST or posedge CLR_OUT_B) begin
		if (SYS_RST || CLR_OUT_B) begin
			Q_B <= '0;
		end else if (b_pend && (mode == MODE_SDP || mode == MODE_TDP)) begin
			Q_B <= next_q_b;
		end
	end

	// user must not trust data flagged here
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			RDW_CLASH <= RST_FLAG;
		end else begin
			RDW_CLASH <= next_clash;
		end
	end

	// ============================================================
	// Assertions
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	a_tile_size: assert property (TILE >= TILE_SMALL && TILE <= TILE_LARGE)
		else $error("tile size out of range");
	a_cap_fits: assert property (DEPTH * DATA_W_A <= tile_cap(TILE))
		else $error("configuration exceeds tile capacity");
	a_tdp_small: assert property (mode == MODE_TDP && TILE == TILE_SMALL |=> CFG_ERR)
		else $error("true dual-port accepted on small tile");
	a_pack_small: assert property (PACK && TILE == TILE_SMALL |=> CFG_ERR)
		else $error("pack accepted on small tile");
	a_addr_hold: assert property (CE_A && !ADDR_CE_A && !CLR_IN_A
		&& TILE != TILE_SMALL |=> a_addr == $past(a_addr))
		else $error("address moved while address enable low");
	a_sdp_width: assert property (mode == MODE_SDP && !PACK |=> !CFG_ERR)
		else $error("simple dual-port refused");
	a_tdp_width: assert property (mode == MODE_TDP && !PACK
		&& TILE != TILE_SMALL |=> !CFG_ERR)
		else $error("true dual-port refused on larger tile");
	a_in_clear: assert property (CLR_IN_A |-> a_addr == '0 && !a_we)
		else $error("input registers not cleared");
	a_clr_next: assert property (CLR_IN_A && !CLR_OUT_A && !CE_A
		##1 !CLR_IN_A && !CLR_OUT_A ##1 !CLR_OUT_A |-> Q_A == $past(a_old))
		else $error("cleared input not shown at next edge");
	a_out_clear: assert property (CLR_OUT_A |-> Q_A == '0)
		else $error("output clear not seen");
	a_same_new: assert property (a_wr && mode != MODE_SHIFT && !CLR_OUT_A
		##1 !CLR_OUT_A |-> Q_A == $past(merge(a_old, a_din, a_mask)))
		else $error("same-port read missed new data");
	a_mixed_flag: assert property (next_clash && !b_wr && !CLR_OUT_B
		&& (mode == MODE_SDP || mode == MODE_TDP) ##1 !CLR_OUT_B
		|-> RDW_CLASH && Q_B == $past(pick(b_old, b_sel)))
		else $error("mixed-port collision not flagged or not old data");
	a_ce_gate: assert property (!CE_A |=> !a_wr)
		else $error("write without clock enable");

endmodule

// ===== verification/ertile_user.sv
`timescale 1ns/1ns
module ertile_user (
	// Clock
	input  wire logic clk,
	// Port B drive
	output logic        ce_b,
	output logic        we_b,
	output logic [6:0]  addr_b,
	output logic [35:0] din_b,
	output logic [3:0]  be_b
);
	initial begin
		ce_b = 1'b0;
		we_b = 1'b0;
		addr_b = 7'h00;
		din_b = 36'h0;
		be_b = 4'h0;
	end
	// ============================================================
	// One port B access, answer settled on return
	task automatic op_b(input logic we, input logic [6:0] addr, input logic [35:0] data);
		@(negedge clk);
		ce_b = 1'b1;
		we_b = we;
		addr_b = addr;
		din_b = data;
		be_b = 4'hf;
		@(negedge clk);
		ce_b = 1'b0;
		we_b = 1'b0;
		din_b = ~din_b;
		@(negedge clk);
	endtask
endmodule

// ===== verification/tb_ertile_top.sv
`timescale 1ns/1ns
module tb_ertile_top;
	import ertile_pkg::*;
	logic        clk = 1'b0, rst = 1'b1, pack = 1'b0, ce_a = 1'b0, adce_a = 1'b1;
	logic        we_a = 1'b0, clr_in_a = 1'b0, clr_out_a = 1'b0;
	logic [2:0]  mode = 3'h3;
	logic [6:0]  addr_a = 7'h00;
	logic [35:0] din_a = 36'h0, q_a, q_b, din_b;
	logic [3:0]  be_a = 4'hf, be_b;
	logic        ce_b, we_b, cfg_err, clash;
	logic [6:0]  addr_b;
	int          mismatches = 0, n_checks = 0, cycles = 0;
	localparam logic [35:0] D5 = 36'h123456789, D7 = 36'hab00cd00e, D0 = 36'h0f0f0f0f0;
	always #2 clk = ~clk;
	ertile_user ertile_user_inst (.clk(clk), .ce_b(ce_b), .we_b(we_b), .addr_b(addr_b),
		.din_b(din_b), .be_b(be_b));
	ertile_top ertile_top_inst (.CLK(clk), .SYS_RST(rst), .MODE(mode), .PACK(pack),
		.CE_A(ce_a), .ADDR_CE_A(adce_a), .WE_A(we_a), .ADDR_A(addr_a), .DIN_A(din_a),
		.BE_A(be_a), .CLR_IN_A(clr_in_a), .CLR_OUT_A(clr_out_a), .Q_A(q_a),
		.CE_B(ce_b), .ADDR_CE_B(1'b1), .WE_B(we_b), .ADDR_B(addr_b), .DIN_B(din_b),
		.BE_B(be_b), .CLR_IN_B(1'b0), .CLR_OUT_B(1'b0), .Q_B(q_b),
		.CFG_ERR(cfg_err), .RDW_CLASH(clash));
	// ============================================================
	// Helpers
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic op_a(input logic we, input logic [6:0] addr, input logic [35:0] data,
		input logic [3:0] be, input logic adce);
		@(negedge clk);
		ce_a = 1'b1;
		we_a = we;
		addr_a = addr;
		din_a = data;
		be_a = be;
		adce_a = adce;
		@(negedge clk);
		ce_a = 1'b0;
		we_a = 1'b0;
		din_a = ~din_a;
		adce_a = 1'b1;
		@(negedge clk);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			print_verdict();
		end
	end
	// ============================================================
	// Tests
	initial begin
		repeat (3) @(negedge clk);
		rst = 1'b0;
		chk(q_a, 36'h0); // reset state
		chk({35'h0, cfg_err}, 36'h0); // error flag at its reset value
		op_a(1'b1, 7'h05, D5, 4'hf, 1'b1); // write shows new word
		chk(q_a, D5); // new data
		op_a(1'b1, 7'h05, 36'hfffffffff, 4'h1, 1'b1); // low unit only
		chk(q_a, D5 | 36'h1ff); // merged word
		op_a(1'b1, 7'h00, D0, 4'hf, 1'b1);
		op_a(1'b1, 7'h07, D7, 4'hf, 1'b1);
		ertile_user_inst.op_b(1'b0, 7'h05, 36'h0); // port B read
		chk(q_b, D5 | 36'h1ff); // shared array
		ertile_user_inst.op_b(1'b1, 7'h06, D7 ^ D5); // port B write
		op_a(1'b0, 7'h06, 36'h0, 4'hf, 1'b1);
		chk(q_a, D7 ^ D5); // seen on port A
		fork
			op_a(1'b1, 7'h07, D0, 4'hf, 1'b1);
			ertile_user_inst.op_b(1'b0, 7'h07, 36'h0); // mixed-port collision
		join
		chk({35'h0, clash}, 36'h1); // collision flagged
		chk(q_b, D7); // old data chosen
		// Clock enable low: nothing captured
		@(negedge clk);
		we_a = 1'b1;
		addr_a = 7'h05;
		din_a = 36'h0;
		repeat (2) @(negedge clk);
		chk({35'h0, clash}, 36'h0); // flag stands one cycle
		we_a = 1'b0;
		op_a(1'b0, 7'h05, 36'h0, 4'hf, 1'b1); // gated write
		chk(q_a, D5 | 36'h1ff); // unchanged word
		op_a(1'b0, 7'h07, 36'h0, 4'hf, 1'b1);
		op_a(1'b0, 7'h05, 36'h0, 4'hf, 1'b0); // address held
		chk(q_a, D0); // old address used
		op_a(1'b0, 7'h05, 36'h0, 4'hf, 1'b1);
		clr_in_a = 1'b1;
		#1 chk(q_a, D5 | 36'h1ff); // output waits for an edge
		@(negedge clk);
		clr_in_a = 1'b0;
		chk(q_a, D0); // cleared address read at the edge
		repeat (2) @(negedge clk);
		clr_out_a = 1'b1;
		#1 chk(q_a, 36'h0); // immediate clear
		@(negedge clk);
		chk(q_a, 36'h0); // held while clear stands
		clr_out_a = 1'b0;
		mode = 3'h6;
		op_a(1'b1, 7'h00, D5, 4'hf, 1'b1); // ROM refuses writes
		chk(q_a, D0); // ROM still reads
		mode = 3'h3;
		op_a(1'b0, 7'h00, 36'h0, 4'hf, 1'b1);
		chk(q_a, D0); // contents kept
		mode = 3'h7;
		repeat (2) @(negedge clk);
		chk({35'h0, cfg_err}, 36'h1); // illegal mode
		mode = 3'h3;
		repeat (2) @(negedge clk);
		chk({35'h0, cfg_err}, 36'h0); // legal again
		// Simple dual-port: port B reads only
		mode = 3'h1;
		ertile_user_inst.op_b(1'b1, 7'h06, D0); // port B write refused
		ertile_user_inst.op_b(1'b0, 7'h06, 36'h0); // port B reads
		chk(q_b, D7 ^ D5); // word kept and read back
		chk({35'h0, cfg_err}, 36'h0); // legal on this tile
		// Single-port: port B ignored
		mode = 3'h0;
		ertile_user_inst.op_b(1'b0, 7'h05, 36'h0); // port B unused
		chk(q_b, D7 ^ D5); // port B output not updated
		op_a(1'b0, 7'h05, 36'h0, 4'hf, 1'b1); // single-port read
		chk(q_a, D5 | 36'h1ff); // port A still served
		// Pack: port A lower half, port B upper half
		mode = 3'h3;
		pack = 1'b1;
		op_a(1'b0, 7'h45, 36'h0, 4'hf, 1'b1); // port A in lower half
		chk(q_a, D5 | 36'h1ff); // word 5 read
		ertile_user_inst.op_b(1'b1, 7'h05, D7); // port B in upper half
		pack = 1'b0;
		op_a(1'b0, 7'h45, 36'h0, 4'hf, 1'b1);
		chk(q_a, D7); // upper word written
		chk({35'h0, cfg_err}, 36'h0); // no error flag three edges after pack is cleared
		// Shift register: pointer from slot 0, full words
		mode = 3'h2;
		op_a(1'b0, 7'h05, D5, 4'h0, 1'b1); // shift ignores address and enables
		chk(q_a, D0); // old slot 0 word from the earlier port A write
		mode = 3'h3;
		op_a(1'b0, 7'h00, 36'h0, 4'hf, 1'b1);
		chk(q_a, D5); // shift wrote slot 0
		print_verdict();
	end
endmodule
